//--- logic/rswd_regs.svh
// Register map, field positions, reset values and timing counts of the reset unit
//
// Notes on behaviour
// - While in reset all port latches are forced to all ones.
// - Reset returns registers to reset values; data memory is never touched.
// - Leaving reset selects the internal oscillator at its slowest setting.
// - Fetch starts at address zero once the clock source is stable.
// - Power-up drives reset pin low until 100 ms after supply is good.
// - Power-on sets supply monitor flag; every other cause clears it.
// - Supply drop drives pin low, resets core, recovers like power-on.
// - After pin release hold reset at least 12 cycles, then flag pin.
// - Enabled clock loss resets, flags one else zero, pin undriven.
// - Writing one to clock loss flag enables the detector.
// - Comparator flag write enables low comparator reset; flag shows cause.
// - Convert start flag write makes input an active-low level reset.
// - Convert start input used as reset never triggers conversions.
// - Watchdog is 21-bit counter; overflow resets without driving pin.
// - 0xa5 enables and restarts watchdog; any reset does so too, longest.
// - 0xde then 0xad within 4 cycles disables; otherwise ignored.
// - 0xff locks out disable until reset, no enable or restart.
// - Timeout is four to the power three plus interval field clocks.
// - Reading control returns interval, 111b after any reset.
`ifndef RSWD_REGS_SVH
`define RSWD_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RSWD_OFS_CAUSE 8'h00
`define RSWD_OFS_WDOG 8'h04

// ----------------------------------------------------------------------------
// Cause register bits
// ----------------------------------------------------------------------------
`define RSWD_BIT_PIN 0
`define RSWD_BIT_POWER 1
`define RSWD_BIT_CLKLOSS 2
`define RSWD_BIT_WDOG 3
`define RSWD_BIT_COMP 5
`define RSWD_BIT_CONV 6

// ----------------------------------------------------------------------------
// Watchdog control
// ----------------------------------------------------------------------------
`define RSWD_KEY_RESTART 8'ha5
`define RSWD_KEY_DIS1 8'hde
`define RSWD_KEY_DIS2 8'had
`define RSWD_KEY_LOCK 8'hff
`define RSWD_WDOG_CMD_BIT 7
`define RSWD_WDOG_ACTIVE_BIT 4
`define RSWD_IVAL_RESET 3'h7
`define RSWD_DIS_WINDOW 4

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define RSWD_PORT_RESET 8'hff
`define RSWD_FETCH_RESET 16'h0000
`define RSWD_CLK_MHZ 100
`define RSWD_SUPPLY_TIMEOUT_MS 100
`define RSWD_SUPPLY_TIMEOUT_CYC (`RSWD_SUPPLY_TIMEOUT_MS * 1000 * `RSWD_CLK_MHZ)
`define RSWD_PIN_HOLD_CYC 12

`endif

//--- logic/rswd_pkg.sv
// Types shared by the reset and watchdog unit
package rswd_pkg;

  typedef enum logic [1:0]
  {
    ST_POWER,
    ST_HOLD,
    ST_CLKWAIT,
    ST_RUN
  } rswd_state_type;

  typedef struct packed
  {
    logic conv;
    logic comp;
    logic wdog;
    logic clkloss;
    logic power;
    logic pin;
  } rswd_cause_type;

endpackage

//--- logic/rswd_top.sv
// Reset source collector, cause flags and watchdog timer with AHB-Lite access
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`include "rswd_regs.svh"

module rswd_top
  import rswd_pkg::*;
#(
  parameter int unsigned SUPPLY_TIMEOUT_CYC = `RSWD_SUPPLY_TIMEOUT_CYC,
  parameter int unsigned PIN_HOLD_CYC = `RSWD_PIN_HOLD_CYC,
  parameter int unsigned WDOG_WIDTH = 21
)
(
  // Clock and power-on reset
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [7:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Reset sources
  input wire logic RST_PIN_N_I,
  input wire logic SUPPLY_LOW_I,
  input wire logic SUPPLY_MONITOR_ENABLE_PIN_I,
  input wire logic CLOCK_LOST_I,
  input wire logic COMPARATOR_I,
  input wire logic CONVERT_START_INPUT_I,
  input wire logic CLOCK_STABLE_I,
  // Reset pin drive
  output logic RST_PIN_O,
  output logic RST_PIN_OE_N_O,
  // System side
  output logic SYS_RESET_N_O,
  output logic [7:0] PORT_LATCH_O,
  output logic CLOCK_SEL_EXT_O,
  output logic FETCH_START_O,
  output logic [15:0] FETCH_ADDR_O,
  output logic ADC_CONVERT_START_O
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam logic [23:0] SUPPLY_LAST = 24'(SUPPLY_TIMEOUT_CYC - 1);
  localparam logic [3:0] PIN_LAST = 4'(PIN_HOLD_CYC - 1);

  rswd_state_type state_q;
  rswd_cause_type cause_q;
  rswd_cause_type hit;
  logic [23:0] supply_cnt_q;
  logic [3:0] hold_cnt_q;
  logic [1:0] pin_sync_q;
  logic [1:0] comp_sync_q;
  logic [1:0] conv_sync_q;
  logic [1:0] lost_sync_q;
  logic pin_n;
  logic comp_s;
  logic conv_n;
  logic lost_s;
  logic power_en_q;
  logic clkloss_en_q;
  logic comp_en_q;
  logic conv_en_q;
  logic supply_fail;
  logic any_src;
  logic in_run;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic wr_cause;
  logic wr_wdog;
  logic [7:0] wdata;
  logic wdog_en_q;
  logic wdog_lock_q;
  logic [2:0] ival_q;
  logic [WDOG_WIDTH-1:0] wdog_cnt_q;
  logic [2:0] dis_win_q;
  logic wdog_over;
  logic conv_prev_q;

  // Timeout: 4^(3+ival) = 2^(6+2*ival) clock periods
  function automatic logic [WDOG_WIDTH-1:0] wdog_limit(input logic [2:0] ival);
    logic [WDOG_WIDTH-1:0] one;
    one = WDOG_WIDTH'(1);
    wdog_limit = (one << (5'd6 + {1'b0, ival, 1'b0})) - one;
  endfunction

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    pin_sync_q <= {pin_sync_q[0], RST_PIN_N_I};
    comp_sync_q <= {comp_sync_q[0], COMPARATOR_I};
    conv_sync_q <= {conv_sync_q[0], CONVERT_START_INPUT_I};
    lost_sync_q <= {lost_sync_q[0], CLOCK_LOST_I};
  end

  assign pin_n = pin_sync_q[1];
  assign comp_s = comp_sync_q[1];
  assign conv_n = conv_sync_q[1];
  assign lost_s = lost_sync_q[1];

  // --------------------------------------------------------------------------
  // Source qualification
  // --------------------------------------------------------------------------
  assign in_run = (state_q == ST_RUN);
  assign supply_fail = SUPPLY_LOW_I && SUPPLY_MONITOR_ENABLE_PIN_I && power_en_q;

  always_comb
  begin
    hit.power = supply_fail;
    hit.pin = !pin_n;
    hit.clkloss = clkloss_en_q && lost_s;
    hit.comp = comp_en_q && !comp_s;
    hit.conv = conv_en_q && !conv_n;
    hit.wdog = in_run && wdog_over;
  end

  assign any_src = |hit;

  // --------------------------------------------------------------------------
  // Reset sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      state_q <= ST_POWER;
      supply_cnt_q <= 24'h000000;
      hold_cnt_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        ST_POWER:
        begin
          hold_cnt_q <= 4'h0;
          if (SUPPLY_LOW_I)
          begin
            supply_cnt_q <= 24'h000000;
          end
          else if (supply_cnt_q == SUPPLY_LAST)
          begin
            state_q <= ST_HOLD;
          end
          else
          begin
            supply_cnt_q <= supply_cnt_q + 24'h000001;
          end
        end
        ST_HOLD:
        begin
          if (hit.power)
          begin
            state_q <= ST_POWER;
            supply_cnt_q <= 24'h000000;
          end
          else if (any_src)
          begin
            hold_cnt_q <= 4'h0;
          end
          else if (hold_cnt_q == PIN_LAST)
          begin
            state_q <= ST_CLKWAIT;
          end
          else
          begin
            hold_cnt_q <= hold_cnt_q + 4'h1;
          end
        end
        ST_CLKWAIT:
        begin
          if (hit.power)
          begin
            state_q <= ST_POWER;
            supply_cnt_q <= 24'h000000;
          end
          else if (any_src)
          begin
            state_q <= ST_HOLD;
            hold_cnt_q <= 4'h0;
          end
          else if (CLOCK_STABLE_I)
          begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (hit.power)
          begin
            state_q <= ST_POWER;
            supply_cnt_q <= 24'h000000;
          end
          else if (any_src)
          begin
            state_q <= ST_HOLD;
            hold_cnt_q <= 4'h0;
          end
        end
        default:
        begin
          state_q <= ST_POWER;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Cause flags: latched on a supply reset, on entry into reset from a running system, or on the pin while held
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      cause_q <= '0;
      cause_q.power <= 1'b1;
    end
    else if (hit.power)
    begin
      cause_q <= '0;
      cause_q.power <= 1'b1;
    end
    else if (in_run && any_src)
    begin
      cause_q <= hit;
    end
    // Own pin drive after a supply reset must not look like a pin cause
    else if (!in_run && state_q != ST_POWER && hit.pin && !cause_q.power)
    begin
      cause_q <= '0;
      cause_q.pin <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------------
  assign wdata = HWDATA_I[7:0];
  assign wr_cause = wr_pend_q && (wr_addr_q == `RSWD_OFS_CAUSE) && in_run;
  assign wr_wdog = wr_pend_q && (wr_addr_q == `RSWD_OFS_WDOG) && in_run;

  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      HRDATA_O <= 32'h00000000;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
    else
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      wr_pend_q <= 1'b0;
      if (HSEL_I && HTRANS_I[1] && HREADY_I)
      begin
        wr_pend_q <= HWRITE_I;
        wr_addr_q <= {HADDR_I[7:2], 2'b00};
        HRDATA_O <= 32'h00000000;
        if (!HWRITE_I && HADDR_I[7:2] == 6'(`RSWD_OFS_CAUSE >> 2))
        begin
          HRDATA_O[6:0] <= {cause_q.conv, cause_q.comp, 1'b0, cause_q.wdog,
                            cause_q.clkloss, cause_q.power, cause_q.pin};
        end
        else if (!HWRITE_I && HADDR_I[7:2] == 6'(`RSWD_OFS_WDOG >> 2))
        begin
          HRDATA_O[`RSWD_WDOG_ACTIVE_BIT] <= wdog_en_q;
          HRDATA_O[2:0] <= ival_q;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Source enables
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      power_en_q <= 1'b1;
      clkloss_en_q <= 1'b0;
      comp_en_q <= 1'b0;
      conv_en_q <= 1'b0;
    end
    else if (!in_run)
    begin
      clkloss_en_q <= 1'b0;
      comp_en_q <= 1'b0;
      conv_en_q <= 1'b0;
      power_en_q <= 1'b1;
    end
    else if (wr_cause)
    begin
      power_en_q <= wdata[`RSWD_BIT_POWER];
      clkloss_en_q <= wdata[`RSWD_BIT_CLKLOSS];
      comp_en_q <= wdata[`RSWD_BIT_COMP];
      conv_en_q <= wdata[`RSWD_BIT_CONV];
    end
  end

  // --------------------------------------------------------------------------
  // Watchdog control
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I || !in_run)
    begin
      wdog_en_q <= 1'b1;
      wdog_lock_q <= 1'b0;
      ival_q <= `RSWD_IVAL_RESET;
      dis_win_q <= 3'h0;
    end
    else
    begin
      if (dis_win_q != 3'h0)
      begin
        dis_win_q <= dis_win_q - 3'h1;
      end
      if (wr_wdog)
      begin
        dis_win_q <= 3'h0;
        if (wdata == `RSWD_KEY_RESTART)
        begin
          wdog_en_q <= 1'b1;
        end
        else if (wdata == `RSWD_KEY_DIS1)
        begin
          dis_win_q <= 3'(`RSWD_DIS_WINDOW);
        end
        else if (wdata == `RSWD_KEY_DIS2)
        begin
          if (dis_win_q != 3'h0 && !wdog_lock_q)
          begin
            wdog_en_q <= 1'b0;
          end
        end
        else if (wdata == `RSWD_KEY_LOCK)
        begin
          wdog_lock_q <= 1'b1;
        end
        else if (!wdata[`RSWD_WDOG_CMD_BIT])
        begin
          ival_q <= wdata[2:0];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Watchdog counter
  // --------------------------------------------------------------------------
  // Compare at or above: a shortened interval must not let the count run on to wrap
  assign wdog_over = wdog_en_q && (wdog_cnt_q >= wdog_limit(ival_q));

  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I || !in_run)
    begin
      wdog_cnt_q <= '0;
    end
    else if (wr_wdog && wdata == `RSWD_KEY_RESTART)
    begin
      wdog_cnt_q <= '0;
    end
    else if (wdog_en_q && !wdog_over)
    begin
      wdog_cnt_q <= wdog_cnt_q + WDOG_WIDTH'(1);
    end
  end

  // --------------------------------------------------------------------------
  // System outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      RST_PIN_O <= 1'b0;
      RST_PIN_OE_N_O <= 1'b0;
      SYS_RESET_N_O <= 1'b0;
      PORT_LATCH_O <= `RSWD_PORT_RESET;
      CLOCK_SEL_EXT_O <= 1'b0;
      FETCH_START_O <= 1'b0;
      FETCH_ADDR_O <= `RSWD_FETCH_RESET;
    end
    else
    begin
      RST_PIN_O <= 1'b0;
      RST_PIN_OE_N_O <= !(state_q == ST_POWER || hit.power);
      SYS_RESET_N_O <= in_run && !any_src;
      if (!in_run)
      begin
        PORT_LATCH_O <= `RSWD_PORT_RESET;
        CLOCK_SEL_EXT_O <= 1'b0;
        FETCH_ADDR_O <= `RSWD_FETCH_RESET;
      end
      FETCH_START_O <= (state_q == ST_CLKWAIT) && CLOCK_STABLE_I && !any_src;
    end
  end

  // --------------------------------------------------------------------------
  // Conversion start: falling edge of the input, blocked while it is a reset
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      conv_prev_q <= 1'b1;
      ADC_CONVERT_START_O <= 1'b0;
    end
    else
    begin
      conv_prev_q <= conv_n;
      ADC_CONVERT_START_O <= conv_prev_q && !conv_n && !conv_en_q;
    end
  end

endmodule

//--- verification/rswd_properties.sv
// Port-level assertions for the reset source and watchdog unit
module rswd_properties
  import rswd_pkg::*;
(
  // Clock, reset and bus
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic HSEL_I,
  input wire logic [7:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  // Sources
  input wire logic RST_PIN_N_I,
  input wire logic SUPPLY_LOW_I,
  input wire logic SUPPLY_MONITOR_ENABLE_PIN_I,
  input wire logic CLOCK_STABLE_I,
  // Outputs watched
  input wire logic RST_PIN_O,
  input wire logic RST_PIN_OE_N_O,
  input wire logic SYS_RESET_N_O,
  input wire logic [7:0] PORT_LATCH_O,
  input wire logic CLOCK_SEL_EXT_O,
  input wire logic FETCH_START_O,
  input wire logic [15:0] FETCH_ADDR_O,
  input wire logic ADC_CONVERT_START_O
);
  logic wr_cause_q;
  logic conv_armed_q;
  logic pwr_en_q;

  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  // ----------------------------------------------------------------------
  // Source enables as last written by software
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I || !SYS_RESET_N_O)
    begin
      wr_cause_q <= 1'b0;
      conv_armed_q <= 1'b0;
      pwr_en_q <= 1'b1;
    end
    else
    begin
      wr_cause_q <= HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I && HADDR_I == 8'h00;
      if (wr_cause_q)
      begin
        conv_armed_q <= HWDATA_I[6];
        pwr_en_q <= HWDATA_I[1];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  latch_in_reset_a: assert property (!SYS_RESET_N_O && !$past(SYS_RESET_N_O)
    |-> PORT_LATCH_O == 8'hff) else $error("port latch not all ones in reset");
  clock_default_a: assert property (!SYS_RESET_N_O && !$past(SYS_RESET_N_O)
    |-> !CLOCK_SEL_EXT_O) else $error("external clock selected in reset");
  pin_drive_hold_a: assert property (!RST_PIN_OE_N_O
    |-> !RST_PIN_O ##1 !SYS_RESET_N_O) else $error("pin driven but core not in reset");
  fetch_addr_a: assert property (FETCH_START_O
    |-> FETCH_ADDR_O == 16'h0000 && CLOCK_STABLE_I) else $error("bad fetch start");
  supply_pin_a: assert property (SUPPLY_LOW_I && SUPPLY_MONITOR_ENABLE_PIN_I && pwr_en_q
    |-> ##[1:4] !RST_PIN_OE_N_O) else $error("supply drop did not drive pin");
  pin_hold_a: assert property ($rose(RST_PIN_N_I) && !SYS_RESET_N_O
    |-> ##12 !SYS_RESET_N_O) else $error("reset left early after pin release");
  pin_reset_a: assert property (!RST_PIN_N_I [*4]
    |-> !SYS_RESET_N_O) else $error("low pin did not hold reset");
  no_pin_drive_a: assert property ($fell(RST_PIN_OE_N_O)
    |-> SUPPLY_LOW_I || $past(SUPPLY_LOW_I) || $past(SUPPLY_LOW_I, 2)
    || $past(SUPPLY_LOW_I, 3)) else $error("pin driven by non-supply reset");
  conv_block_a: assert property (conv_armed_q
    |-> !ADC_CONVERT_START_O) else $error("conversion started by armed input");
endmodule

bind rswd_top rswd_properties i_props
(
  .CLOCK_I, .RESETN_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HWDATA_I,
  .HREADY_I, .RST_PIN_N_I, .SUPPLY_LOW_I, .SUPPLY_MONITOR_ENABLE_PIN_I,
  .CLOCK_STABLE_I, .RST_PIN_O, .RST_PIN_OE_N_O, .SYS_RESET_N_O, .PORT_LATCH_O,
  .CLOCK_SEL_EXT_O, .FETCH_START_O, .FETCH_ADDR_O, .ADC_CONVERT_START_O
);

//--- verification/rswd_src_model.sv
// Behavioural reset sources and clock source beside the unit
module rswd_src_model
(
  // Clock and feedback
  input wire logic clk_i,
  input wire logic sys_reset_n_i,
  // Source levels
  output logic ext_pin_n_o,
  output logic supply_low_o,
  output logic mon_en_o,
  output logic clk_lost_o,
  output logic comp_o,
  output logic conv_o,
  output logic clk_stable_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned stable_lag = 16;
  int unsigned lag_q = 16;
  logic sys_q = 1'b0;
  logic [4:0] act_q = 5'h00;

  assign ext_pin_n_o = !act_q[0];
  assign supply_low_o = act_q[1];
  assign mon_en_o = 1'b1;
  assign clk_lost_o = act_q[2];
  assign comp_o = !act_q[3]; // Comparator on and settled before arming
  assign conv_o = !act_q[4];
  assign clk_stable_o = (lag_q == 0);

  // Clock source settles slowly after each reset entry
  always_ff @(posedge clk_i)
  begin
    sys_q <= sys_reset_n_i;
    if (sys_q && !sys_reset_n_i)
      lag_q <= stable_lag;
    else if (lag_q != 0)
      lag_q <= lag_q - 1;
  end

  task automatic hit(input int k, input int n);
    act_q[k] <= 1'b1;
    repeat (n) @(posedge clk_i);
    act_q[k] <= 1'b0;
  endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the reset source and watchdog unit
`include "rswd_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic rst_n;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic ext_pin_n;
  logic pin_n;
  logic supply_low;
  logic mon_en;
  logic clk_lost;
  logic comp;
  logic conv;
  logic clk_stable;
  logic pin_o;
  logic pin_oe_n;
  logic sys_n;
  logic [7:0] latch;
  logic clk_sel;
  logic [15:0] fetch_addr;
  logic adc;
  logic [31:0] rd;
  int bad_count = 0;
  int num_checks = 0;
  int adc_count = 0;
  int oe_low = 0;
  int n;
  int m;
  logic [7:0] arm [5] = '{8'h00, 8'h00, 8'h06, 8'h22, 8'h42};
  logic [31:0] cause [5] = '{32'h01, 32'h02, 32'h04, 32'h20, 32'h40};

  // Reset line has a pull-up; anyone may pull it low
  assign pin_n = ext_pin_n && (pin_oe_n || pin_o);

  rswd_top #(.SUPPLY_TIMEOUT_CYC(20)) i_dut
  (
    .CLOCK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .RST_PIN_N_I(pin_n),
    .SUPPLY_LOW_I(supply_low), .SUPPLY_MONITOR_ENABLE_PIN_I(mon_en),
    .CLOCK_LOST_I(clk_lost), .COMPARATOR_I(comp), .CONVERT_START_INPUT_I(conv),
    .CLOCK_STABLE_I(clk_stable), .RST_PIN_O(pin_o), .RST_PIN_OE_N_O(pin_oe_n),
    .SYS_RESET_N_O(sys_n), .PORT_LATCH_O(latch), .CLOCK_SEL_EXT_O(clk_sel),
    .FETCH_START_O(), .FETCH_ADDR_O(fetch_addr), .ADC_CONVERT_START_O(adc)
  );

  rswd_src_model i_src
  (
    .clk_i(clk), .sys_reset_n_i(sys_n), .ext_pin_n_o(ext_pin_n), .supply_low_o(supply_low),
    .mon_en_o(mon_en), .clk_lost_o(clk_lost), .comp_o(comp), .conv_o(conv),
    .clk_stable_o(clk_stable)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (adc === 1'b1)
      adc_count++;
    if (pin_oe_n === 1'b0)
      oe_low++;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_sys(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (sys_n !== lvl)
    begin
      @(posedge clk);
      cnt++;
      if (cnt > lim)
      begin
        bad_count++;
        $display("BAD %0t system reset wait ran out", $time);
        give_verdict();
      end
    end
  endtask

  // One bus edge, stretched while the slave holds ready low
  task automatic rdy_edge;
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      k++;
      if (k > 20)
      begin
        bad_count++;
        $display("BAD %0t bus ready wait ran out", $time);
        give_verdict();
      end
      @(posedge clk);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    rdy_edge();
    htrans <= 2'b00;
    hwdata <= wd;
    rdy_edge();
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (12) @(posedge clk);
    check(latch, 32'hff);
    check(clk_sel, 32'h0);
    rst_n <= 1'b1;
    repeat (18) @(posedge clk);
    check(pin_oe_n, 32'h0);
    wait_sys(1'b1, 300, n);
    check(fetch_addr, 32'h0);
    rchk(`RSWD_OFS_CAUSE, 32'h02);
    rchk(8'h08, 32'h0);
    bus(1'b1, 8'h0c, 32'hff);
    rchk(`RSWD_OFS_CAUSE, 32'h02);
    // Each reset source but the watchdog in turn; armable ones first tried while disarmed
    for (int i = 0; i < 5; i++)
    begin
      m = oe_low;
      if (arm[i] != 8'h00)
      begin
        n = adc_count;
        i_src.hit(i, 3);
        repeat (6) @(posedge clk);
        check(sys_n, 32'h1);
        if (i == 4)
          check(adc_count, n + 1);
        bus(1'b1, `RSWD_OFS_CAUSE, {24'h0, arm[i]});
      end
      n = adc_count;
      i_src.hit(i, 6);
      check(sys_n, 32'h0);
      check(adc_count, n);
      wait_sys(1'b1, 300, n);
      if (i == 0)
        check(n >= 12, 32'h1);
      check(oe_low != m, i == 1);
      rchk(`RSWD_OFS_CAUSE, cause[i]);
    end
    // Watchdog commands, lock and intervals
    rchk(`RSWD_OFS_WDOG, 32'h17);
    bus(1'b1, `RSWD_OFS_WDOG, 32'hde);
    bus(1'b1, `RSWD_OFS_WDOG, 32'had);
    rchk(`RSWD_OFS_WDOG, 32'h07);
    bus(1'b1, `RSWD_OFS_WDOG, 32'hff);
    rchk(`RSWD_OFS_WDOG, 32'h07);
    bus(1'b1, `RSWD_OFS_WDOG, 32'ha5);
    rchk(`RSWD_OFS_WDOG, 32'h17);
    bus(1'b1, `RSWD_OFS_WDOG, 32'hde);
    bus(1'b1, `RSWD_OFS_WDOG, 32'had);
    rchk(`RSWD_OFS_WDOG, 32'h17);
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, `RSWD_OFS_WDOG, 32'(i));
      rchk(`RSWD_OFS_WDOG, 32'h10 + 32'(i));
      repeat (40) @(posedge clk);
      bus(1'b1, `RSWD_OFS_WDOG, 32'ha5);
      m = 4 ** (3 + i);
      wait_sys(1'b0, 1100, n);
      check(n >= m - 2 && n <= m + 4, 32'h1);
      wait_sys(1'b1, 300, n);
      rchk(`RSWD_OFS_CAUSE, 32'h08);
      rchk(`RSWD_OFS_WDOG, 32'h17);
    end
    bus(1'b1, `RSWD_OFS_WDOG, 32'hde);
    repeat (6) @(posedge clk);
    bus(1'b1, `RSWD_OFS_WDOG, 32'had);
    rchk(`RSWD_OFS_WDOG, 32'h17);
    give_verdict();
  end
endmodule
